// ---- include/wdt_pkg.sv ----
package wdt_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int HADDR_W = 32;
  localparam int HDATA_W = 32;
  localparam int IDX_W = 8;
  localparam int IDX_LSB = 2;
  localparam int HTRANS_ACTIVE_BIT = 1;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] STATUS_IDX = 8'h00;
  localparam logic [IDX_W-1:0] IRQ_ENABLE_IDX = 8'h01;
  localparam logic [IDX_W-1:0] PRIV_CONTROL_IDX = 8'h02;
  localparam logic [IDX_W-1:0] COUNT_IDX = 8'h03;
  localparam logic [IDX_W-1:0] CLOCK_CONTROL_THREE_IDX = 8'h41;
  localparam logic [IDX_W-1:0] WATCHDOG_CONTROL_IDX = 8'hE1;

  // ==========================================================================
  // watchdog_control fields
  localparam int CTL_RST_EN_BIT = 7;
  localparam int CTL_RUN_PD_BIT = 6;
  localparam int CTL_ENABLE_BIT = 5;
  localparam int CTL_CLEAR_BIT = 4;
  localparam int CTL_RUN_IDLE_BIT = 3;
  localparam int CTL_PS_MSB = 2;
  localparam int CTL_PS_LSB = 0;
  localparam logic [7:0] CTL_POR_VALUE = 8'h07;
  localparam logic [7:0] CTL_STICKY_MASK = 8'hE0;
  localparam logic [7:0] CTL_FREE_MASK = 8'h0F;
  localparam logic [7:0] CTL_PRIV_MASK = 8'hEF;

  // ==========================================================================
  // clock_control_three fields
  localparam int CK3_CLKSEL_MSB = 7;
  localparam int CK3_CLKSEL_LSB = 6;
  localparam int CK3_TAP_BIT = 4;
  localparam logic [7:0] CK3_POR_VALUE = 8'h00;
  localparam logic [7:0] CK3_WRITE_MASK = 8'hD0;

  // ==========================================================================
  // Own status and enable fields, fuse and pin positions
  localparam int STAT_FLAG_BIT = 0;
  localparam int IRQ_FLAG_EN_BIT = 0;
  localparam int IRQ_GROUP_EN_BIT = 1;
  localparam logic [1:0] IRQ_ALL_ON = 2'h3;
  localparam int FUSE_RST_EN_BIT = 0;
  localparam int FUSE_NONSTOP_BIT = 1;
  localparam int PIN_LRC_BIT = 0;
  localparam int PIN_EXT_BIT = 1;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    CLK_LRC = 2'h0,
    CLK_EXT = 2'h1,
    CLK_SYSDIV = 2'h2,
    CLK_SER0 = 2'h3
  } clk_src_e;

  typedef enum logic [1:0] {
    INIT_SYNC0 = 2'h0,
    INIT_SYNC1 = 2'h1,
    INIT_LOAD = 2'h3,
    INIT_RUN = 2'h2
  } init_state_e;

  // ==========================================================================
  // Timing
  localparam int SYSCLK_DIV = 12;
  localparam int DIV_W = 4;
  localparam int LRC_FREQ_HZ = 32000;
  localparam int PERIOD_TAP0_BASE_MS = 16;
  localparam int PERIOD_TAP1_BASE_US = 125;
  localparam int PERIOD_TAP0_BASE_TICKS = PERIOD_TAP0_BASE_MS * LRC_FREQ_HZ / 1000;
  localparam int PERIOD_TAP1_BASE_TICKS = PERIOD_TAP1_BASE_US * LRC_FREQ_HZ / 1000000;
  localparam int TICK_CNT_W = 18;

endpackage

// ---- rtl/watchdog_timer.sv ----
`timescale 1ns/1ps

module watchdog_timer #(
  parameter int PRE_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [wdt_pkg::HADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [wdt_pkg::HDATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [wdt_pkg::HDATA_W-1:0] hrdata,
  input wire logic lrcOscPin,
  input wire logic extClockPin,
  input wire logic ser0TimerOvf,
  input wire logic coreIdle,
  input wire logic corePowerDown,
  input wire logic warmReset,
  input wire logic fuseResetEnable,
  input wire logic fuseNonstop,
  output logic wdtIrq,
  output logic wdtResetReq,
  output logic wakeReq
);
  import wdt_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic hitIdx(input logic [HADDR_W-1:0] a, input logic [IDX_W-1:0] idx);
    return (a[HADDR_W-1:IDX_LSB+IDX_W] == '0) && (a[IDX_LSB+IDX_W-1:IDX_LSB] == idx)
      && (a[IDX_LSB-1:0] == '0);
  endfunction

  function automatic logic preDone(input logic [PRE_W-1:0] pre, input logic [2:0] ps);
    logic [PRE_W-1:0] mask;
    mask = ~({PRE_W{1'b1}} << (32'(ps) + 1));
    return &(pre | ~mask);
  endfunction

  function automatic logic [TICK_CNT_W-1:0] periodTicks(input logic [2:0] ps, input logic tap);
    logic [TICK_CNT_W-1:0] base;
    base = tap ? TICK_CNT_W'(PERIOD_TAP1_BASE_TICKS) : TICK_CNT_W'(PERIOD_TAP0_BASE_TICKS);
    return base << ps;
  endfunction

  // ==========================================================================
  // Declarations
  logic [1:0] pinMeta_q, pinSync_q, pinLast_q, pinRise;
  logic [1:0] fuseMeta_q, fuseSync_q;
  init_state_e initState_q;
  logic [DIV_W-1:0] divCnt_q;
  logic sysDivTick;
  logic [HADDR_W-1:0] addr_q;
  logic wrPend_q, rdPend_q;
  logic [HDATA_W-1:0] hrdata_q, readVal;
  logic accept, wrCtl, wrPriv, wrCk3, wrStat, wrIrqEn, clearReq;
  logic [7:0] wd;
  logic [7:0] ctrl_q, ck3_q;
  logic flag_q, rstReq_q, wake_q;
  logic [1:0] irqEn_q;
  logic [PRE_W-1:0] pre_q;
  logic [CNT_W-1:0] cnt_q;
  logic enable, runIdle, runPd, rstEn, tapSel, srcOk, idleOk, pdOk;
  logic [2:0] ps;
  clk_src_e srcSel;
  logic srcTick, countTick, preOut, evt;

  // ==========================================================================
  // Pin and fuse synchronisers
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinMeta_q <= 2'h0;
      pinSync_q <= 2'h0;
      pinLast_q <= 2'h0;
    end
    else
    begin
      pinMeta_q <= {extClockPin, lrcOscPin};
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end

  // Each rising source edge becomes one core-clock tick, so none is lost
  assign pinRise = pinSync_q & ~pinLast_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fuseMeta_q <= 2'h0;
      fuseSync_q <= 2'h0;
    end
    else
    begin
      fuseMeta_q <= {fuseNonstop, fuseResetEnable};
      fuseSync_q <= fuseMeta_q;
    end
  end

  // ==========================================================================
  // Power-up fuse load sequence
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      initState_q <= INIT_SYNC0;
    end
    else
    begin
      case (initState_q)
        INIT_SYNC0: initState_q <= INIT_SYNC1;
        INIT_SYNC1: initState_q <= INIT_LOAD;
        INIT_LOAD: initState_q <= INIT_RUN;
        INIT_RUN: initState_q <= INIT_RUN;
        default: initState_q <= INIT_SYNC0;
      endcase
    end
  end

  // ==========================================================================
  // System clock / 12 tick
  assign sysDivTick = (divCnt_q == DIV_W'(SYSCLK_DIV - 1));

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      divCnt_q <= '0;
    end
    else
    begin
      divCnt_q <= sysDivTick ? '0 : divCnt_q + 1'b1;
    end
  end

  // ==========================================================================
  // AHB-Lite slave: writes zero-wait, reads one wait state
  assign accept = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
  assign wd = hwdata[7:0];
  assign wrCtl = wrPend_q && hitIdx(addr_q, WATCHDOG_CONTROL_IDX);
  assign wrPriv = wrPend_q && hitIdx(addr_q, PRIV_CONTROL_IDX);
  assign wrCk3 = wrPend_q && hitIdx(addr_q, CLOCK_CONTROL_THREE_IDX);
  assign wrStat = wrPend_q && hitIdx(addr_q, STATUS_IDX);
  assign wrIrqEn = wrPend_q && hitIdx(addr_q, IRQ_ENABLE_IDX);
  assign clearReq = (wrCtl || wrPriv) && wd[CTL_CLEAR_BIT];
  assign hreadyout = !rdPend_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // Wait state lets a write just before a read land first
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      hrdata_q <= '0;
    end
    else
    begin
      if (accept)
      begin
        addr_q <= haddr;
      end
      wrPend_q <= accept && hwrite;
      rdPend_q <= accept && !hwrite;
      if (rdPend_q)
      begin
        hrdata_q <= readVal;
      end
    end
  end

  always_comb
  begin
    readVal = '0;
    if (hitIdx(addr_q, WATCHDOG_CONTROL_IDX) || hitIdx(addr_q, PRIV_CONTROL_IDX))
    begin
      readVal[7:0] = ctrl_q;
    end
    else if (hitIdx(addr_q, CLOCK_CONTROL_THREE_IDX))
    begin
      readVal[7:0] = ck3_q;
    end
    else if (hitIdx(addr_q, STATUS_IDX))
    begin
      readVal[STAT_FLAG_BIT] = flag_q;
    end
    else if (hitIdx(addr_q, IRQ_ENABLE_IDX))
    begin
      readVal[1:0] = irqEn_q;
    end
    else if (hitIdx(addr_q, COUNT_IDX))
    begin
      readVal[PRE_W+CNT_W-1:0] = {pre_q, cnt_q};
    end
  end

  // ==========================================================================
  // Control registers, reset by power-on only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q <= CTL_POR_VALUE;
    end
    else if (initState_q == INIT_LOAD)
    begin
      ctrl_q[CTL_RST_EN_BIT] <= fuseSync_q[FUSE_RST_EN_BIT];
      ctrl_q[CTL_RUN_PD_BIT] <= fuseSync_q[FUSE_NONSTOP_BIT];
    end
    else if (wrPriv)
    begin
      ctrl_q <= wd & CTL_PRIV_MASK;
    end
    else if (wrCtl)
    begin
      ctrl_q <= ((ctrl_q | wd) & CTL_STICKY_MASK) | (wd & CTL_FREE_MASK);
    end
  end

  // Reset value selects the RC oscillator
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ck3_q <= CK3_POR_VALUE;
    end
    else if (wrCk3)
    begin
      ck3_q <= wd & CK3_WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqEn_q <= 2'h0;
    end
    else if (wrIrqEn)
    begin
      irqEn_q <= wd[1:0];
    end
  end

  // ==========================================================================
  // Source select and counting conditions
  assign enable = ctrl_q[CTL_ENABLE_BIT];
  assign runIdle = ctrl_q[CTL_RUN_IDLE_BIT];
  assign runPd = ctrl_q[CTL_RUN_PD_BIT];
  assign rstEn = ctrl_q[CTL_RST_EN_BIT];
  assign ps = ctrl_q[CTL_PS_MSB:CTL_PS_LSB];
  assign tapSel = ck3_q[CK3_TAP_BIT];
  assign srcSel = tapSel ? CLK_LRC : clk_src_e'(ck3_q[CK3_CLKSEL_MSB:CK3_CLKSEL_LSB]);
  assign srcOk = (srcSel == CLK_LRC) || (srcSel == CLK_EXT);
  assign idleOk = !coreIdle || runIdle || fuseSync_q[FUSE_NONSTOP_BIT];
  assign pdOk = !corePowerDown || (runPd && srcOk);

  always_comb
  begin
    case (srcSel)
      CLK_LRC: srcTick = pinRise[PIN_LRC_BIT];
      CLK_EXT: srcTick = pinRise[PIN_EXT_BIT];
      CLK_SYSDIV: srcTick = sysDivTick;
      CLK_SER0: srcTick = ser0TimerOvf;
      default: srcTick = 1'b0;
    endcase
  end

  // Core clock assumed alive in power-down; ticks stop there unless runPd is set and the source is the RC or external pin
  assign countTick = srcTick && enable && idleOk && pdOk && !warmReset;
  assign preOut = countTick && preDone(pre_q, ps);
  assign evt = preOut && (tapSel ? cnt_q[0] : &cnt_q) && !clearReq;

  // ==========================================================================
  // Prescaler and counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= '0;
      cnt_q <= '0;
    end
    else if (warmReset || clearReq)
    begin
      pre_q <= '0;
      cnt_q <= '0;
    end
    else if (countTick)
    begin
      pre_q <= preOut ? '0 : pre_q + 1'b1;
      if (preOut)
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Flag, reset and wake requests
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      flag_q <= evt || (flag_q && !(wrStat && wd[STAT_FLAG_BIT]));
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstReq_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      rstReq_q <= evt && rstEn;
      wake_q <= evt && corePowerDown;
    end
  end

  assign wdtIrq = flag_q && irqEn_q[IRQ_FLAG_EN_BIT] && irqEn_q[IRQ_GROUP_EN_BIT];
  assign wdtResetReq = rstReq_q;
  assign wakeReq = wake_q;

  // ==========================================================================
  // Checks
  logic [TICK_CNT_W-1:0] ticks_q;
  logic periodValid_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ticks_q <= '0;
      periodValid_q <= 1'b1;
    end
    else if (warmReset || clearReq || evt)
    begin
      ticks_q <= '0;
      periodValid_q <= 1'b1;
    end
    else
    begin
      if (countTick)
      begin
        ticks_q <= ticks_q + 1'b1;
      end
      if (wrCtl || wrPriv || wrCk3)
      begin
        periodValid_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_CLEAR_ZEROES:
    assert property (clearReq |=> (cnt_q == '0) && (pre_q == '0))
    else $error("clear did not zero counter");
  AST_ENABLE_STICKY:
    assert property (enable && !wrPriv |=> enable)
    else $error("enable dropped without privileged write");
  AST_SET_ONLY:
    assert property (wrCtl && initState_q == INIT_RUN |=>
      (ctrl_q & CTL_STICKY_MASK) == (($past(ctrl_q) | $past(wd)) & CTL_STICKY_MASK))
    else $error("normal write cleared a set-only bit");
  AST_PRIV_LOAD:
    assert property (wrPriv && initState_q == INIT_RUN |=> ctrl_q == ($past(wd) & CTL_PRIV_MASK))
    else $error("privileged write not loaded");
  AST_FLAG_SET:
    assert property (evt |=> flag_q)
    else $error("event did not set flag");
  AST_IRQ_RAISE:
    assert property (evt && irqEn_q == IRQ_ALL_ON && !wrIrqEn |=> wdtIrq)
    else $error("interrupt not raised");
  AST_RESET_REQ:
    assert property (evt |=> wdtResetReq == $past(rstEn))
    else $error("reset request wrong");
  AST_RETAIN:
    assert property (warmReset && !wrCtl && !wrPriv && initState_q == INIT_RUN |=> $stable(ctrl_q))
    else $error("control changed on warm reset");
  AST_IDLE_HOLD:
    assert property (coreIdle && !runIdle && !fuseSync_q[FUSE_NONSTOP_BIT] |-> !countTick)
    else $error("counted in idle");
  AST_IDLE_RUN:
    assert property (srcTick && enable && coreIdle && fuseSync_q[FUSE_NONSTOP_BIT]
      && !corePowerDown && !warmReset |-> countTick)
    else $error("nonstop did not count in idle");
  AST_WAKE:
    assert property (evt && corePowerDown |=> wakeReq)
    else $error("no wake on power-down event");
  AST_PD_GATE:
    assert property (corePowerDown && !(runPd && srcOk) |-> !countTick)
    else $error("counted in power-down");
  AST_PERIOD:
    assert property (evt && periodValid_q |-> ticks_q + 1'b1 == periodTicks(ps, tapSel))
    else $error("period wrong for prescale and tap");
  AST_TAP1_SRC:
    assert property (tapSel && !pinRise[PIN_LRC_BIT] |-> !srcTick)
    else $error("tap one used non RC source");
  AST_FUSE_LOAD:
    assert property (initState_q == INIT_LOAD |=> rstEn == $past(fuseSync_q[FUSE_RST_EN_BIT])
      && runPd == $past(fuseSync_q[FUSE_NONSTOP_BIT]))
    else $error("fuse load wrong");
  AST_FLAG_W1C:
    assert property (wrStat && wd[STAT_FLAG_BIT] && !evt |=> !flag_q)
    else $error("flag not cleared");

  COV_RESET_EVENT: cover property (evt && rstEn ##1 wdtResetReq);
  COV_FLAG_CLEAR: cover property (flag_q ##1 wrStat && wd[STAT_FLAG_BIT] ##1 !flag_q);
  COV_IDLE_NONSTOP: cover property (coreIdle && !runIdle && countTick);
  COV_PRIV_DISABLE: cover property (enable && wrPriv ##1 !enable);

endmodule

// ---- bench/watchdog_timer_with_clock_select_tb.sv ----
`timescale 1ns/1ps

module watchdog_timer_with_clock_select_tb;
  import wdt_pkg::*;

  // ==========================================================================
  // Signals and model state
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [HADDR_W-1:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [HDATA_W-1:0] hwdata = '0;
  logic hreadyout;
  logic hresp;
  logic [HDATA_W-1:0] hrdata;
  logic lrcOscPin = 1'b0;
  logic extClockPin = 1'b0;
  logic ser0TimerOvf = 1'b0;
  logic coreIdle = 1'b0;
  logic corePowerDown = 1'b0;
  logic warmReset = 1'b0;
  logic fuseResetEnable = 1'b0;
  logic fuseNonstop = 1'b0;
  logic wdtIrq;
  logic wdtResetReq;
  logic wakeReq;
  int n_fail = 0;
  int n_compared = 0;
  int nRst = 0;
  int nWake = 0;
  int expRst = 0;
  int expWake = 0;
  int ctlM = 0;
  int ck3M = 0;
  int irqM = 0;
  int unsigned seed = 57;

  // Slave select and size held constant: single word transfers only
  watchdog_timer u_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .hsel(1'b1),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'h2),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .lrcOscPin(lrcOscPin),
    .extClockPin(extClockPin),
    .ser0TimerOvf(ser0TimerOvf),
    .coreIdle(coreIdle),
    .corePowerDown(corePowerDown),
    .warmReset(warmReset),
    .fuseResetEnable(fuseResetEnable),
    .fuseNonstop(fuseNonstop),
    .wdtIrq(wdtIrq),
    .wdtResetReq(wdtResetReq),
    .wakeReq(wakeReq)
  );

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // Pulses are one cycle wide, so count them at every edge
  always @(posedge core_clk)
  begin
    if (wdtResetReq === 1'b1)
      nRst <= nRst + 1;
    if (wakeReq === 1'b1)
      nWake <= nWake + 1;
  end

  // ==========================================================================
  // Helpers
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic end_of_test();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitRdy();
    int k;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, hreadyout, 1'b1);
      end_of_test();
    end
  endtask

  // Upper data bits get noise: only the low byte is meaningful
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     output logic [31:0] r);
    logic [31:0] x;
    x = rnd();
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    waitRdy();
    htrans <= 2'h0;
    hwdata <= {x[31:8], d[7:0]};
    waitRdy();
    r = hrdata;
  endtask

  task automatic regWr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    int v;
    v = int'(d[7:0]);
    bus(1'b1, idx, d, r);
    if (idx == WATCHDOG_CONTROL_IDX)
      ctlM = ((ctlM | v) & 8'hE0) | (v & 8'h0F);
    if (idx == PRIV_CONTROL_IDX)
      ctlM = v & 8'hEF;
    if (idx == CLOCK_CONTROL_THREE_IDX)
      ck3M = v & 8'hD0;
    if (idx == IRQ_ENABLE_IDX)
      irqM = v & 3;
  endtask

  task automatic regRd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk(r, exp);
  endtask

  // Source 0 RC pin, 1 external pin, 2 core/12 (just waits), 3 serial pulse
  task automatic tick(input int s, input int n);
    int h;
    repeat (n)
    begin
      h = 2 + int'(rnd() % 2);
      if (s == 3)
        h = 1;
      if (s == 2)
        h = 6;
      if (s == 0)
        lrcOscPin <= 1'b1;
      if (s == 1)
        extClockPin <= 1'b1;
      if (s == 3)
        ser0TimerOvf <= 1'b1;
      repeat (h) @(posedge core_clk);
      lrcOscPin <= 1'b0;
      extClockPin <= 1'b0;
      ser0TimerOvf <= 1'b0;
      repeat (h) @(posedge core_clk);
    end
  endtask

  // Flag must stay low short of the period and be up at it; m is the margin
  task automatic period(input int s, input int need, input int m);
    tick(s, need - m);
    repeat (8) @(posedge core_clk);
    regRd(STATUS_IDX, 32'h0);
    tick(s, 2 * m - 1);
    repeat (8) @(posedge core_clk);
    regRd(STATUS_IDX, 32'h1);
    chk({31'h0, wdtIrq}, (irqM == 3) ? 32'h1 : 32'h0);
    chk(32'(nRst), 32'(expRst));
    chk(32'(nWake), 32'(expWake));
    regWr(STATUS_IDX, 32'h0);
    regRd(STATUS_IDX, 32'h1);
    regWr(STATUS_IDX, 32'h1);
    regRd(STATUS_IDX, 32'h0);
    chk({31'h0, wdtIrq}, 32'h0);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    ctlM = 8'h07;
    repeat (4) @(posedge core_clk);
    regRd(WATCHDOG_CONTROL_IDX, 32'(ctlM));
    regRd(CLOCK_CONTROL_THREE_IDX, 32'h0);
    regWr(8'h10, 32'hFF);
    regRd(8'h10, 32'h0);
    regWr(CLOCK_CONTROL_THREE_IDX, 32'hFF);
    regRd(CLOCK_CONTROL_THREE_IDX, 32'(ck3M));
    regWr(CLOCK_CONTROL_THREE_IDX, 32'h10);
    regWr(WATCHDOG_CONTROL_IDX, 32'h20);
    regWr(WATCHDOG_CONTROL_IDX, 32'h08);
    regRd(WATCHDOG_CONTROL_IDX, 32'(ctlM));
    for (int p = 0; p < 3; p++)
    begin
      regWr(PRIV_CONTROL_IDX, 32'h30 + p);
      period(0, 4 << p, 1);
    end
    regWr(PRIV_CONTROL_IDX, 32'h30);
    tick(0, 3);
    regRd(COUNT_IDX, 32'((3 % 2) << 8 | 3 / 2));
    regWr(WATCHDOG_CONTROL_IDX, 32'h10);
    regRd(COUNT_IDX, 32'h0);
    period(0, 4, 1);
    for (int i = 1; i < 4; i += 2)
    begin
      regWr(IRQ_ENABLE_IDX, i);
      regWr(PRIV_CONTROL_IDX, 32'h30);
      period(0, 4, 1);
    end
    coreIdle <= 1'b1;
    regWr(PRIV_CONTROL_IDX, 32'h30);
    tick(0, 4);
    repeat (8) @(posedge core_clk);
    regRd(STATUS_IDX, 32'h0);
    regWr(PRIV_CONTROL_IDX, 32'h38);
    period(0, 4, 1);
    coreIdle <= 1'b0;
    corePowerDown <= 1'b1;
    regWr(PRIV_CONTROL_IDX, 32'h30);
    tick(0, 4);
    repeat (8) @(posedge core_clk);
    regRd(STATUS_IDX, 32'h0);
    regWr(PRIV_CONTROL_IDX, 32'h70);
    expWake++;
    period(0, 4, 1);
    regWr(CLOCK_CONTROL_THREE_IDX, 32'h80);
    regWr(PRIV_CONTROL_IDX, 32'h70);
    tick(2, 600);
    regRd(STATUS_IDX, 32'h0);
    corePowerDown <= 1'b0;
    regWr(CLOCK_CONTROL_THREE_IDX, 32'h10);
    regWr(PRIV_CONTROL_IDX, 32'hB0);
    expRst++;
    period(0, 4, 1);
    warmReset <= 1'b1;
    repeat (4) @(posedge core_clk);
    warmReset <= 1'b0;
    repeat (2) @(posedge core_clk);
    regRd(WATCHDOG_CONTROL_IDX, 32'(ctlM));
    regWr(WATCHDOG_CONTROL_IDX, 32'h00);
    regRd(WATCHDOG_CONTROL_IDX, 32'(ctlM));
    regWr(PRIV_CONTROL_IDX, 32'h00);
    regRd(WATCHDOG_CONTROL_IDX, 32'h0);
    for (int s = 0; s < 4; s++)
    begin
      regWr(CLOCK_CONTROL_THREE_IDX, s << 6);
      regWr(PRIV_CONTROL_IDX, 32'h30);
      period(s, 512, (s == 2) ? 4 : 1);
    end
    // Second power-on with both straps high
    fuseResetEnable <= 1'b1;
    fuseNonstop <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    ctlM = 8'hC7;
    ck3M = 0;
    irqM = 0;
    repeat (4) @(posedge core_clk);
    regRd(WATCHDOG_CONTROL_IDX, 32'(ctlM));
    regRd(CLOCK_CONTROL_THREE_IDX, 32'h0);
    regWr(CLOCK_CONTROL_THREE_IDX, 32'h10);
    coreIdle <= 1'b1;
    regWr(PRIV_CONTROL_IDX, 32'h30);
    period(0, 4, 1);
    end_of_test();
  end
endmodule
